// >>> hw/uhftx_ctrl.v
// Operation
// - Band select high picks divide-by-32, low picks divide-by-64.
// - Phase detector out of limits disables the RF output stage.
// - Modulation low: on/off keying, data 1 turns output stage on.
// - Modulation high: shift keying, data 1 closes crystal-pull switch.
// - Bit-rate reference toggles at crystal frequency divided by 64.
// - Standby keeps every function off.
// - While acquiring, RF stays off but the reference clock runs.
// - Within lock-in range, wait for first data; lock may still settle.
// - Data rising edge starts sending; later data modulate the output.
// - Out-of-lock: RF off, reference clock keeps running.
// - Undervoltage switches all off, latched until enable goes low.
`timescale 1ns/1ps
`include "uhftx_regs.vh"
module uhftx_ctrl (
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // Host control pins
   input wire enable_i,
   input wire serial_data_i,
   input wire band_select_i,
   input wire mod_select_i,
   // Analog status
   input wire pll_in_range_i,
   input wire pfd_in_limits_i,
   input wire undervoltage_cutoff_level_i,
   // Outputs
   output reg bit_rate_reference_out_o,
   output reg antenna_drive_out_o,
   output reg crystal_pull_switch_pin_o,
   output reg pll_enable_o,
   output reg [6:0] pll_divider_o,
   output reg [5:0] state_o,
   output reg data_overrun_o
);
   // ****************************************
   // States
   // ****************************************
   localparam ST_STANDBY = 6'h01;
   localparam ST_ACQUIRE = 6'h02;
   localparam ST_WAIT = 6'h04;
   localparam ST_SEND = 6'h08;
   localparam ST_UNLOCK = 6'h10;
   localparam ST_SHUTDOWN = 6'h20;

   // ****************************************
   // Input synchronisers
   // ****************************************
   reg [6:0] sync_a;
   reg [6:0] sync_b;
   wire [6:0] raw_in;
   assign raw_in = {mod_select_i, band_select_i, undervoltage_cutoff_level_i,
                    pfd_in_limits_i, pll_in_range_i, serial_data_i, enable_i};
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1) begin : g_sync
         always @(posedge core_clk_i) begin
            if (!resetn_i) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate
   wire en_s = sync_b[0];
   wire data_s = sync_b[1];
   wire range_s = sync_b[2];
   wire pfd_ok_s = sync_b[3];
   wire uv_s = sync_b[4];
   wire band_s = sync_b[5];
   wire mod_s = sync_b[6];
   reg data_d;
   wire data_rise = data_s && !data_d;

   // ****************************************
   // Main state machine
   // ****************************************
   reg [5:0] state;
   reg [5:0] next_state;
   reg [15:0] lock_cnt;
   wire lock_done = (lock_cnt == `UHFTX_LOCK_CYCLES);

   always @* begin
      next_state = state;
      if (!en_s) begin
         next_state = ST_STANDBY;
      end else if (uv_s || state == ST_SHUTDOWN) begin
         next_state = ST_SHUTDOWN;
      end else begin
         case (state)
            ST_STANDBY: begin
               next_state = ST_ACQUIRE;
            end
            ST_ACQUIRE: begin
               if (range_s) begin
                  next_state = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!pfd_ok_s) begin
                  next_state = ST_UNLOCK;
               end else if (data_rise) begin
                  next_state = ST_SEND;
               end
            end
            ST_SEND: begin
               if (!pfd_ok_s) begin
                  next_state = ST_UNLOCK;
               end
            end
            ST_UNLOCK: begin
               if (pfd_ok_s && range_s) begin
                  next_state = ST_WAIT;
               end
            end
            default: begin
               next_state = ST_STANDBY;
            end
         endcase
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state <= ST_STANDBY;
         lock_cnt <= 16'h0000;
         data_d <= 1'b0;
      end else begin
         state <= next_state;
         data_d <= data_s;
         // Lock-in timer runs from entry into the waiting state
         if (next_state != ST_WAIT && next_state != ST_SEND) begin
            lock_cnt <= 16'h0000;
         end else if (!lock_done) begin
            lock_cnt <= lock_cnt + 16'h0001;
         end
      end
   end

   // ****************************************
   // Data path through the sample FIFO
   // ****************************************
   // Samples queue in the FIFO so the modulator sees them in order,
   // one per cycle; a full FIFO while sending flags an overrun.
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_data;
   wire sending = (state == ST_SEND);
   wire send_next = (next_state == ST_SEND);
   uhftx_fifo #(
      .W(`UHFTX_FIFO_W),
      .D(`UHFTX_FIFO_D),
      .AW(3)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .flush_i(!sending),
      .in_valid_i(sending),
      .in_data_i(data_s),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_data),
      .out_ready_i(sending && pfd_ok_s)
   );

   // ****************************************
   // Reference divider
   // ****************************************
   reg [5:0] ref_cnt;
   // Gated on the coming state so the clock stops in step with state_o
   wire ref_run = (next_state != ST_STANDBY) &&
                  (next_state != ST_SHUTDOWN);

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ref_cnt <= 6'h00;
         bit_rate_reference_out_o <= 1'b0;
      end else if (!ref_run) begin
         ref_cnt <= 6'h00;
         bit_rate_reference_out_o <= 1'b0;
      end else begin
         ref_cnt <= ref_cnt + 6'h01;
         if (ref_cnt == `UHFTX_REF_HALF || ref_cnt == `UHFTX_REF_DIV) begin
            bit_rate_reference_out_o <= ~bit_rate_reference_out_o;
         end
      end
   end

   // ****************************************
   // Output stage and switches
   // ****************************************
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         antenna_drive_out_o <= 1'b0;
         crystal_pull_switch_pin_o <= 1'b0;
         pll_enable_o <= 1'b0;
         pll_divider_o <= `UHFTX_DIV_HIGH_BAND;
         state_o <= ST_STANDBY;
         data_overrun_o <= 1'b0;
      end else begin
         state_o <= next_state;
         pll_enable_o <= ref_run;
         pll_divider_o <= band_s ? `UHFTX_DIV_LOW_BANDS
                                 : `UHFTX_DIV_HIGH_BAND;
         if (!send_next || !pfd_ok_s) begin
            // RF dead outside transmit or on lock loss
            antenna_drive_out_o <= 1'b0;
            crystal_pull_switch_pin_o <= 1'b0;
         end else if (fifo_out_valid) begin
            if (mod_s) begin
               antenna_drive_out_o <= 1'b1;
               crystal_pull_switch_pin_o <= fifo_out_data;
            end else begin
               antenna_drive_out_o <= fifo_out_data;
               crystal_pull_switch_pin_o <= 1'b0;
            end
         end
         if (state == ST_STANDBY) begin
            data_overrun_o <= 1'b0;
         end else if (sending && !fifo_in_ready) begin
            data_overrun_o <= 1'b1;
         end
      end
   end
endmodule

// >>> hw/uhftx_regs.vh
`ifndef UHFTX_REGS_VH
`define UHFTX_REGS_VH
// Feedback divider ratios per band select level
`define UHFTX_DIV_LOW_BANDS 7'h20
`define UHFTX_DIV_HIGH_BAND 7'h40
// Reference clock toggles every half of 64 crystal cycles
`define UHFTX_REF_DIV 6'h3f
`define UHFTX_REF_HALF 6'h1f
// Lock-in time in microseconds, and the core clock period in ns
`define UHFTX_LOCK_IN_US 16'h0064
`define UHFTX_CLK_NS 16'h0032
// 100 us over 50 ns is 2000 cycles; kept as a plain constant because the
// product overflows a 16-bit expression
`define UHFTX_LOCK_CYCLES 16'h07d0
// Sample FIFO geometry
`define UHFTX_FIFO_W 1
`define UHFTX_FIFO_D 8
`endif

// >>> hw/uhftx_fifo.v
`timescale 1ns/1ps
module uhftx_fifo #(
   parameter W = 1,
   parameter D = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   input wire flush_i,
   // Write side
   input wire in_valid_i,
   input wire [W-1:0] in_data_i,
   output wire in_ready_o,
   // Read side
   output wire out_valid_o,
   output wire [W-1:0] out_data_o,
   input wire out_ready_i
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   assign in_ready_o = (count != D[AW:0]);
   assign out_valid_o = (count != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   always @(posedge core_clk_i) begin
      if (!resetn_i || flush_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// >>> tb/uhftx_ctrl_sva.sv
`timescale 1ns/1ps
module uhftx_ctrl_sva (
   // Clock and reset
   input logic core_clk_i,
   input logic resetn_i,
   // Pins in
   input logic enable_i,
   input logic band_select_i,
   input logic mod_select_i,
   input logic pfd_in_limits_i,
   // Pins out
   input logic bit_rate_reference_out_o,
   input logic antenna_drive_out_o,
   input logic crystal_pull_switch_pin_o,
   input logic pll_enable_o,
   input logic [6:0] pll_divider_o,
   input logic [5:0] state_o
);
   // ********
   // Checks
   // ********
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   logic ref_d;
   logic seen;
   logic [5:0] cnt;
   // First period is uneven, so timing starts after one toggle
   always @(posedge core_clk_i) begin
      ref_d <= bit_rate_reference_out_o;
      if (!resetn_i || !pll_enable_o) begin
         cnt <= 6'h00;
         seen <= 1'b0;
      end else if (ref_d != bit_rate_reference_out_o) begin
         cnt <= 6'h01;
         seen <= 1'b1;
      end else begin
         cnt <= cnt + 6'h01;
      end
   end
   sequence s_en_up;
      $rose(enable_i) ##1 enable_i [*3];
   endsequence
   sequence s_en_down;
      $fell(enable_i) ##1 !enable_i [*2];
   endsequence
   chk_band_div: assert property (state_o[3] |->
      pll_divider_o == (band_select_i ? 7'h20 : 7'h40)) else $error("div");
   chk_pfd_rf: assert property (!pfd_in_limits_i [*3] |=>
      !antenna_drive_out_o) else $error("rf on unlocked");
   chk_ook_pull: assert property (state_o[3] && !mod_select_i |->
      !crystal_pull_switch_pin_o) else $error("pull in ook");
   chk_ref_period: assert property (ref_d != bit_rate_reference_out_o
      && seen && pll_enable_o |-> cnt == 6'h20) else $error("ref period");
   chk_idle_quiet: assert property (state_o[0] | state_o[5] |->
      !(antenna_drive_out_o | crystal_pull_switch_pin_o | pll_enable_o
      | bit_rate_reference_out_o)) else $error("idle not quiet");
   chk_acq_rf: assert property (state_o == 6'h02 |->
      !antenna_drive_out_o && pll_enable_o) else $error("acquire");
   chk_unlock_rf: assert property (state_o == 6'h10 |->
      !antenna_drive_out_o && pll_enable_o) else $error("unlock");
   chk_uv_latch: assert property (state_o == 6'h20 && enable_i &&
      $past(enable_i) && $past(enable_i, 2) |=> state_o == 6'h20)
      else $error("shutdown left");
   chk_en_start: assert property (s_en_up |=> pll_enable_o)
      else $error("no start");
   chk_en_stop: assert property (s_en_down |=> state_o == 6'h01)
      else $error("no standby");
endmodule
bind uhftx_ctrl uhftx_ctrl_sva uhftx_ctrl_sva_inst (.core_clk_i, .resetn_i,
   .enable_i, .band_select_i, .mod_select_i, .pfd_in_limits_i,
   .bit_rate_reference_out_o, .antenna_drive_out_o,
   .crystal_pull_switch_pin_o, .pll_enable_o, .pll_divider_o, .state_o);

// >>> tb/uhftx_host_model.sv
`timescale 1ns/1ps
module uhftx_host_model (
   // Link side
   input logic link_clk_i,
   input logic load_i,
   input logic [7:0] frame_i,
   // Data pin
   output logic data_o
);
   // ********
   // Data shifter
   // ********
   logic [8:0] shifter = 9'h000;
   // Bits follow the link clock, never the unreliable reference edges
   always @(posedge link_clk_i or posedge load_i)
      if (load_i)
         shifter <= {1'b0, frame_i};
      else
         shifter <= {shifter[7:0], 1'b0};
   assign data_o = shifter[8];
endmodule

// >>> tb/uhftx_ctrl_bench.sv
`timescale 1ns/1ps
module uhftx_ctrl_bench;
   // ********
   // Bench
   // ********
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic enable_i = 1'b0;
   logic band_select_i = 1'b0;
   logic mod_select_i = 1'b0;
   logic pll_in_range_i = 1'b0;
   logic pfd_in_limits_i = 1'b0;
   logic undervoltage_cutoff_level_i = 1'b0;
   logic link_clk = 1'b0;
   logic load = 1'b0;
   logic [7:0] frame = 8'h00;
   logic [5:0] last = 6'h01;
   logic [5:0] expq[$];
   wire serial_data_i;
   wire bit_rate_reference_out_o;
   wire antenna_drive_out_o;
   wire crystal_pull_switch_pin_o;
   wire pll_enable_o;
   wire [6:0] pll_divider_o;
   wire [5:0] state_o;
   wire data_overrun_o;
   int miscompares = 0;
   int n_compared = 0;
   int i;
   int m;
   initial forever #25 core_clk_i = ~core_clk_i;
   uhftx_ctrl uhftx_ctrl_inst (.core_clk_i, .resetn_i, .enable_i,
      .serial_data_i, .band_select_i, .mod_select_i, .pll_in_range_i,
      .pfd_in_limits_i, .undervoltage_cutoff_level_i,
      .bit_rate_reference_out_o, .antenna_drive_out_o,
      .crystal_pull_switch_pin_o, .pll_enable_o, .pll_divider_o,
      .state_o, .data_overrun_o);
   uhftx_host_model uhftx_host_model_inst (.link_clk_i(link_clk),
      .load_i(load), .frame_i(frame), .data_o(serial_data_i));
   task cmp_state(input logic [5:0] e, input logic [5:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] state exp %h got %h", e, g);
      end
   endtask
   task cmp_pin(input logic [6:0] e, input logic [6:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] pins exp %h got %h", e, g);
      end
   endtask
   task cmp_count(input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] ref half period exp %h got %h", e, g);
      end
   endtask
   // Skips the first uneven period, then counts one half period
   task check_ref;
      int n;
      logic r;
      n = 0;
      @(bit_rate_reference_out_o);
      @(bit_rate_reference_out_o);
      r = bit_rate_reference_out_o;
      @(negedge core_clk_i);
      while (bit_rate_reference_out_o === r && n < 100) begin
         @(negedge core_clk_i);
         n++;
      end
      cmp_count(8'h20, 8'(n));
   endtask
   always @(posedge core_clk_i)
      if (!resetn_i)
         last <= state_o;
      else if (state_o !== last) begin
         last <= state_o;
         cmp_state(expq.size() ? expq.pop_front() : 6'h00, state_o);
      end
   task settle;
      for (i = 0; i < 200 && expq.size() > 0; i++) @(negedge core_clk_i);
      if (expq.size() > 0) begin
         miscompares++;
         $display("[FAIL] state wait exp %h got %h", expq[0], state_o);
         expq.delete();
      end
   endtask
   task expect_state(input logic [5:0] s);
      expq.push_back(s);
      settle();
   endtask
   task send(input logic [7:0] f);
      frame = f;
      load = 1'b1;
      #10 load = 1'b0;
      for (i = 0; i < 9; i++) begin
         if (i > 1)
            cmp_pin(mod_select_i ? {5'h00, 1'b1, f[8-i]}
               : {5'h00, f[8-i], 1'b0}, {5'h00, antenna_drive_out_o,
               crystal_pull_switch_pin_o});
         #200 link_clk = 1'b1;
         #200 link_clk = 1'b0;
      end
   endtask
   task report_and_stop;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h77cf1696));
      repeat (6) @(negedge core_clk_i);
      resetn_i = 1'b1;
      for (m = 0; m < 4; m++) begin
         @(negedge core_clk_i);
         band_select_i = m[0];
         mod_select_i = m[1];
         pll_in_range_i = 1'b0;
         pfd_in_limits_i = 1'b1;
         @(negedge core_clk_i) enable_i = 1'b1;
         expect_state(6'h02);
         cmp_pin(7'h04, {4'h0, pll_enable_o, antenna_drive_out_o,
            crystal_pull_switch_pin_o});
         check_ref();
         @(negedge core_clk_i) pll_in_range_i = 1'b1;
         expect_state(6'h04);
         expq.push_back(6'h08);
         send({1'b1, 7'($urandom)});
         settle();
         cmp_pin(band_select_i ? 7'h20 : 7'h40, pll_divider_o);
         cmp_pin(7'h00, {6'h00, data_overrun_o});
         @(negedge core_clk_i) pfd_in_limits_i = 1'b0;
         expect_state(6'h10);
         cmp_pin(7'h04, {4'h0, pll_enable_o, antenna_drive_out_o,
            crystal_pull_switch_pin_o});
         @(negedge core_clk_i) pfd_in_limits_i = 1'b1;
         expect_state(6'h04);
         if (m[0]) begin
            @(negedge core_clk_i) undervoltage_cutoff_level_i = 1'b1;
            expect_state(6'h20);
            cmp_pin(7'h00, {4'h0, pll_enable_o,
               bit_rate_reference_out_o, antenna_drive_out_o});
            @(negedge core_clk_i) undervoltage_cutoff_level_i = 1'b0;
            repeat (20) @(negedge core_clk_i);
         end
         @(negedge core_clk_i) enable_i = 1'b0;
         expect_state(6'h01);
         cmp_pin(7'h00, {4'h0, pll_enable_o,
            bit_rate_reference_out_o, antenna_drive_out_o});
         $display("test %0d done", m);
      end
      report_and_stop();
   end
   initial begin
      #1000000;
      miscompares++;
      report_and_stop();
   end
endmodule
